// ==== tcbo_params.svh ====
// Constants of the timer compare-B and wrap status block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef TCBO_PARAMS_SVH
`define TCBO_PARAMS_SVH
// Register byte offsets
`define TCBO_OFF_CMPB 8'h00
`define TCBO_OFF_WRAP 8'h04
`define TCBO_OFF_CNT0 8'h08
`define TCBO_OFF_CNT1 8'h0c
`define TCBO_OFF_CNT2 8'h10
`define TCBO_OFF_GENERAL_B_REG_CH0 8'h14
`define TCBO_OFF_GENERAL_B_REG_CH1 8'h18
`define TCBO_OFF_GENERAL_B_REG_CH2 8'h1c
`define TCBO_OFF_CTRL 8'h20
`define TCBO_OFF_IRQS 8'h24
`define TCBO_OFF_IRQM 8'h28
// Status/enable reset value and fixed-one bits
`define TCBO_SE_RESET 8'h88
`define TCBO_SE_ONES 8'h88
// Field positions
`define TCBO_EN_LSB 4
`define TCBO_FLAG_LSB 0
`define TCBO_CTRL_RUN 0
`define TCBO_CTRL_PHASE 3
`define TCBO_CTRL_DIR 4
`define TCBO_CTRL_DOWN 5
`define TCBO_CTRL_CAPT 8
// Counter and general register reset values, counter maximum
`define TCBO_CNT_RESET 16'h0000
`define TCBO_GRB_RESET 16'hffff
`define TCBO_CNT_MAX 16'hffff
`endif

// ==== tcbo_pkg.sv ====
// Types of the timer compare-B and wrap status block.
// Assumes the params header is on the include path.
`include "tcbo_params.svh"
package tcbo_pkg;
    // Bus response codes
    typedef logic [1:0] tcbo_resp_t;
    localparam tcbo_resp_t TCBO_OKAY = 2'h0;
    localparam tcbo_resp_t TCBO_SLVERR = 2'h2;
    // Write channel states
    typedef enum logic [2:0] {
        TCBO_W_IDLE = 3'b001,
        TCBO_W_EXEC = 3'b010,
        TCBO_W_RESP = 3'b100
    } tcbo_wstate_e;
endpackage : tcbo_pkg

// ==== tcbo_timer.sv ====
// Three-channel 16-bit timer: compare-B flags, wrap flags, enables, counters.
// Assumes an AXI4-Lite master on aclk; standby is a synchronous level input.
`timescale 1ns/10ps
`include "tcbo_params.svh"
module tcbo_timer #(
    parameter int CH = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic standby,
    input wire logic [CH-1:0] count_tick,
    input wire logic [CH-1:0] capture_in,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [CH-1:0] match_b_irq,
    output logic [CH-1:0] wrap_irq,
    output logic irq
);
    // Combined reset: chip reset or standby
    logic init;
    assign init = !aresetn || standby;

    // Control and data registers
    logic [CH-1:0] match_b_en_q; // Compare-B enables
    logic [CH-1:0] match_b_flag_q; // Compare-B flags
    logic [CH-1:0] wrap_en_q; // Wrap enables
    logic [CH-1:0] wrap_flag_q; // Wrap flags
    logic [15:0] cnt_q [CH]; // Counters
    logic [15:0] grb_q [CH]; // General B registers
    logic [CH-1:0] capt_mode_q; // One selects input capture
    logic run_q; // Counting enable
    logic phase_count_select_q; // Channel 2 phase mode
    logic wrap_flag_direction_q; // One: overflow only
    logic down_q; // Channel 2 direction in phase mode
    logic [CH-1:0] armed_b_q; // Flag read as one
    logic [CH-1:0] armed_w_q;
    logic [1:0] evt_q, evt_msk_q; // Block summary events

    // Write channel
    tcbo_pkg::tcbo_wstate_e wst_q;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_got_q, w_got_q;
    logic wr_fire;
    assign wr_fire = (wst_q == tcbo_pkg::TCBO_W_EXEC);

    // Write acceptance in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wst_q <= tcbo_pkg::TCBO_W_IDLE;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tcbo_pkg::TCBO_OKAY;
        end
        else
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            case (wst_q)
                tcbo_pkg::TCBO_W_IDLE:
                begin
                    // Capture address
                    if (s_axi_awvalid && !aw_got_q && !s_axi_awready)
                    begin
                        s_axi_awready <= 1'b1;
                        aw_got_q <= 1'b1;
                        waddr_q <= s_axi_awaddr;
                    end
                    // Capture data
                    if (s_axi_wvalid && !w_got_q && !s_axi_wready)
                    begin
                        s_axi_wready <= 1'b1;
                        w_got_q <= 1'b1;
                        wdata_q <= s_axi_wdata;
                        wstrb_q <= s_axi_wstrb;
                    end
                    if (aw_got_q && w_got_q)
                        wst_q <= tcbo_pkg::TCBO_W_EXEC;
                end
                tcbo_pkg::TCBO_W_EXEC:
                begin
                    s_axi_bvalid <= 1'b1;
                    s_axi_bresp <= wr_known(waddr_q) ? tcbo_pkg::TCBO_OKAY : tcbo_pkg::TCBO_SLVERR;
                    wst_q <= tcbo_pkg::TCBO_W_RESP;
                end
                tcbo_pkg::TCBO_W_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        s_axi_bvalid <= 1'b0;
                        aw_got_q <= 1'b0;
                        w_got_q <= 1'b0;
                        wst_q <= tcbo_pkg::TCBO_W_IDLE;
                    end
                end
                default:
                    wst_q <= tcbo_pkg::TCBO_W_IDLE;
            endcase
        end
    end

    // Known address check
    function automatic logic wr_known(input logic [7:0] a);
        wr_known = (a <= `TCBO_OFF_IRQM) && (a[1:0] == 2'b00);
    endfunction : wr_known

    // Write decode strobes
    logic wr_cmpb, wr_wrap, wr_ctrl, wr_irqs, wr_irqm;
    logic [CH-1:0] wr_cnt, wr_grb;
    assign wr_cmpb = wr_fire && waddr_q == `TCBO_OFF_CMPB && wstrb_q[0];
    assign wr_wrap = wr_fire && waddr_q == `TCBO_OFF_WRAP && wstrb_q[0];
    assign wr_ctrl = wr_fire && waddr_q == `TCBO_OFF_CTRL && wstrb_q[0] && wstrb_q[1];
    assign wr_irqs = wr_fire && waddr_q == `TCBO_OFF_IRQS && wstrb_q[0];
    assign wr_irqm = wr_fire && waddr_q == `TCBO_OFF_IRQM && wstrb_q[0];

    // Read channel: one read at a time, answer next cycle
    logic rd_take;
    logic [7:0] raddr;
    assign rd_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    assign raddr = s_axi_araddr;

    // Per-channel counting, compare and flag logic
    logic [CH-1:0] match_set, wrap_set;
    genvar g;
    generate
        for (g = 0; g < CH; g++)
        begin : gen_ch
            logic up_wrap, dn_wrap, dn;
            assign dn = (g == 2) && phase_count_select_q && down_q;
            assign wr_cnt[g] = wr_fire && waddr_q == (`TCBO_OFF_CNT0 + 8'(4 * g)) && wstrb_q[0] && wstrb_q[1];
            assign wr_grb[g] = wr_fire && waddr_q == (`TCBO_OFF_GENERAL_B_REG_CH0 + 8'(4 * g)) && wstrb_q[0] && wstrb_q[1];
            assign up_wrap = run_q && count_tick[g] && !dn && cnt_q[g] == `TCBO_CNT_MAX;
            assign dn_wrap = run_q && count_tick[g] && dn && cnt_q[g] == `TCBO_CNT_RESET;
            assign wrap_set[g] = up_wrap || (dn_wrap && !wrap_flag_direction_q);
            assign match_set[g] = capt_mode_q[g] ? capture_in[g] : (cnt_q[g] == grb_q[g]);

            // Counter update
            // Sixteen-bit counters
            always_ff @(posedge aclk)
            begin
                if (init)
                    cnt_q[g] <= `TCBO_CNT_RESET;
                else if (wr_cnt[g])
                    cnt_q[g] <= wdata_q[15:0];
                else if (run_q && count_tick[g])
                    cnt_q[g] <= dn ? cnt_q[g] - 16'h0001 : cnt_q[g] + 16'h0001;
            end

            // General B register and capture
            always_ff @(posedge aclk)
            begin
                if (init)
                    grb_q[g] <= `TCBO_GRB_RESET;
                else if (capt_mode_q[g] && capture_in[g])
                    grb_q[g] <= cnt_q[g];
                else if (wr_grb[g])
                    grb_q[g] <= wdata_q[15:0];
            end

            // Compare-B flag with read-arm clear
            always_ff @(posedge aclk)
            begin
                if (init)
                begin
                    match_b_flag_q[g] <= 1'b0;
                    armed_b_q[g] <= 1'b0;
                end
                else
                begin
                    if (rd_take && raddr == `TCBO_OFF_CMPB && match_b_flag_q[g])
                        armed_b_q[g] <= 1'b1;
                    if (match_set[g])
                        match_b_flag_q[g] <= 1'b1;
                    else if (wr_cmpb && !wdata_q[`TCBO_FLAG_LSB + g] && armed_b_q[g])
                    begin
                        match_b_flag_q[g] <= 1'b0;
                        armed_b_q[g] <= 1'b0;
                    end
                end
            end

            // Wrap flag with read-arm clear
            always_ff @(posedge aclk)
            begin
                if (init)
                begin
                    wrap_flag_q[g] <= 1'b0;
                    armed_w_q[g] <= 1'b0;
                end
                else
                begin
                    if (rd_take && raddr == `TCBO_OFF_WRAP && wrap_flag_q[g])
                        armed_w_q[g] <= 1'b1;
                    if (wrap_set[g])
                        wrap_flag_q[g] <= 1'b1;
                    else if (wr_wrap && !wdata_q[`TCBO_FLAG_LSB + g] && armed_w_q[g])
                    begin
                        wrap_flag_q[g] <= 1'b0;
                        armed_w_q[g] <= 1'b0;
                    end
                end
            end

            // Per-channel request outputs
            // Flag and enable
            always_ff @(posedge aclk)
            begin
                if (init)
                begin
                    match_b_irq[g] <= 1'b0;
                    wrap_irq[g] <= 1'b0;
                end
                else
                begin
                    match_b_irq[g] <= match_b_flag_q[g] && match_b_en_q[g];
                    wrap_irq[g] <= wrap_flag_q[g] && wrap_en_q[g];
                end
            end
        end
    endgenerate

    // Enable bits
    // Reset and standby value
    always_ff @(posedge aclk)
    begin
        if (init)
        begin
            match_b_en_q <= '0;
            wrap_en_q <= '0;
        end
        else
        begin
            if (wr_cmpb)
                match_b_en_q <= wdata_q[`TCBO_EN_LSB +: CH];
            if (wr_wrap)
                wrap_en_q <= wdata_q[`TCBO_EN_LSB +: CH];
        end
    end

    // Control register
    always_ff @(posedge aclk)
    begin
        if (init)
        begin
            run_q <= 1'b0;
            phase_count_select_q <= 1'b0;
            wrap_flag_direction_q <= 1'b0;
            down_q <= 1'b0;
            capt_mode_q <= '0;
        end
        else if (wr_ctrl)
        begin
            run_q <= wdata_q[`TCBO_CTRL_RUN];
            phase_count_select_q <= wdata_q[`TCBO_CTRL_PHASE];
            wrap_flag_direction_q <= wdata_q[`TCBO_CTRL_DIR];
            down_q <= wdata_q[`TCBO_CTRL_DOWN];
            capt_mode_q <= wdata_q[`TCBO_CTRL_CAPT +: CH];
        end
    end

    // Summary sticky events: bit0 any compare-B, bit1 any wrap
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            evt_q <= 2'h0;
            evt_msk_q <= 2'h0;
            irq <= 1'b0;
        end
        else
        begin
            // Set wins over write-one clear
            evt_q <= (evt_q & ~(wr_irqs ? wdata_q[1:0] : 2'h0)) | {(|wrap_set), (|match_set)};
            if (wr_irqm)
                evt_msk_q <= wdata_q[1:0];
            irq <= |(evt_q & evt_msk_q);
        end
    end

    // Status/enable views
    // Fixed-one bits
    logic [7:0] cmpb_view, wrap_view;
    assign cmpb_view = `TCBO_SE_ONES | {1'b0, match_b_en_q, 1'b0, match_b_flag_q};
    assign wrap_view = `TCBO_SE_ONES | {1'b0, wrap_en_q, 1'b0, wrap_flag_q};

    // Read answer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= tcbo_pkg::TCBO_OKAY;
        end
        else
        begin
            s_axi_arready <= rd_take;
            if (rd_take)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= tcbo_pkg::TCBO_OKAY;
                if (raddr == `TCBO_OFF_CMPB)
                    s_axi_rdata <= {24'h0, cmpb_view};
                else if (raddr == `TCBO_OFF_WRAP)
                    s_axi_rdata <= {24'h0, wrap_view};
                else if (raddr == `TCBO_OFF_CNT0)
                    s_axi_rdata <= {16'h0, cnt_q[0]};
                else if (raddr == `TCBO_OFF_CNT1)
                    s_axi_rdata <= {16'h0, cnt_q[1]};
                else if (raddr == `TCBO_OFF_CNT2)
                    s_axi_rdata <= {16'h0, cnt_q[2]};
                else if (raddr == `TCBO_OFF_GENERAL_B_REG_CH0)
                    s_axi_rdata <= {16'h0, grb_q[0]};
                else if (raddr == `TCBO_OFF_GENERAL_B_REG_CH1)
                    s_axi_rdata <= {16'h0, grb_q[1]};
                else if (raddr == `TCBO_OFF_GENERAL_B_REG_CH2)
                    s_axi_rdata <= {16'h0, grb_q[2]};
                else if (raddr == `TCBO_OFF_CTRL)
                    s_axi_rdata <= {21'h0, capt_mode_q, 2'h0, down_q, wrap_flag_direction_q,
                                    phase_count_select_q, 2'h0, run_q};
                else if (raddr == `TCBO_OFF_IRQS)
                    s_axi_rdata <= {30'h0, evt_q};
                else if (raddr == `TCBO_OFF_IRQM)
                    s_axi_rdata <= {30'h0, evt_msk_q};
                else
                begin
                    // Unmapped: error, zero data
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= tcbo_pkg::TCBO_SLVERR;
                end
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : tcbo_timer

// ==== tcbo_timer_props.sv ====
// Port-level checker of the timer compare-B and wrap status block.
// Assumes it is bound into tcbo_timer and sees only its ports.
`timescale 1ns/10ps
module tcbo_timer_props #(
    parameter int CH = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic standby,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic [CH-1:0] match_b_irq,
    input wire logic [CH-1:0] wrap_irq,
    input wire logic irq
);
    // One clock domain, reset disables all
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Read answer of any register
    logic rd_ok;
    assign rd_ok = s_axi_rvalid && s_axi_arready;
    // Outputs quiet right after reset
    reset_quiet_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq
        && match_b_irq == '0 && wrap_irq == '0 && !s_axi_awready && !s_axi_arready)
        else $error("outputs not quiet after reset");
    // Fixed bits and upper bits of status reads
    fixed_ones_a: assert property (rd_ok && (s_axi_araddr == 8'h00 || s_axi_araddr == 8'h04) |->
        s_axi_rdata[7] && s_axi_rdata[3] && s_axi_rdata[31:8] == 24'h0 && s_axi_rresp == 2'h0)
        else $error("fixed-one bits wrong");
    // Read above the last register refused with zero data
    bad_addr_a: assert property (rd_ok && s_axi_araddr > 8'h28 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    // Enabled compare-B flag raises its request
    cmpb_req_a: assert property (rd_ok && s_axi_araddr == 8'h00 && s_axi_rdata[4] && s_axi_rdata[0]
        |-> ##[0:2] match_b_irq[0])
        else $error("compare-B request missing");
    // Enabled wrap flag raises its request
    wrap_req_a: assert property (rd_ok && s_axi_araddr == 8'h04 && s_axi_rdata[4] && s_axi_rdata[0]
        |-> ##[0:2] wrap_irq[0])
        else $error("wrap request missing");
    // Standby drops every compare-B and wrap enable, so their requests fall
    standby_quiet_a: assert property (standby |-> ##2 (match_b_irq == '0 && wrap_irq == '0))
        else $error("requests survive standby");
    // Write answer two cycles after the later handshake
    bresp_time_a: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready, 2) || $past(s_axi_wready, 2))
        else $error("write answer mistimed");
    // Address ready is a one-cycle pulse
    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready held too long");
    // Read address taken together with the answer
    ar_with_r_a: assert property (s_axi_arready |-> s_axi_rvalid)
        else $error("arready without rvalid");
endmodule : tcbo_timer_props
bind tcbo_timer tcbo_timer_props #(.CH(CH)) props_u (.aclk, .aresetn, .standby, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .match_b_irq,
    .wrap_irq, .irq);

// ==== tcbo_timer_bench.sv ====
// Self-checking bench of the timer status block over AXI4-Lite.
// Assumes tcbo_timer with three channels and the package compiled first.
`timescale 1ns/10ps
module tcbo_timer_bench;
    // Timer and bus signals
    logic aclk, aresetn, standby, irq;
    logic [2:0] count_tick, capture_in, match_b_irq, wrap_irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    // Tallies and random state
    int n_mismatch, total_checks;
    logic [15:0] lfsr_q;
    tcbo_timer #(.CH(3)) dut_u (.aclk, .aresetn, .standby, .count_tick, .capture_in, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .match_b_irq, .wrap_irq, .irq);
    // 125 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // Next value of a 16-bit shift register
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
    endfunction : lfsr_next
    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    // Data compare
    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_data
    // Response compare
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk_data({30'h0, got}, {30'h0, exp});
    endtask : chk_resp
    // Request pin compare
    task automatic chk_pin(input logic [2:0] got, input logic [2:0] exp);
        chk_data({29'h0, got}, {29'h0, exp});
    endtask : chk_pin
    // Bounded wait ran out
    task automatic hung();
        n_mismatch++;
        tally_and_finish();
    endtask : hung
    // Write one word, check response
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic bad);
        int i;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        if (i == 40) hung();
        chk_resp(s_axi_bresp, bad ? tcbo_pkg::TCBO_SLVERR : tcbo_pkg::TCBO_OKAY);
        @(posedge aclk);
    endtask : axi_wr
    // Read one word, check data and response
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic bad);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (i == 40) hung();
        chk_data(s_axi_rdata, exp);
        chk_resp(s_axi_rresp, bad ? tcbo_pkg::TCBO_SLVERR : tcbo_pkg::TCBO_OKAY);
        @(posedge aclk);
    endtask : axi_rd
    // Count pulses on selected channels
    task automatic tick(input logic [2:0] m, input int n);
        repeat (n)
        begin
            count_tick <= m;
            @(posedge aclk);
            count_tick <= 3'h0;
            @(posedge aclk);
        end
    endtask : tick
    // Main sequence
    initial
    begin
        aresetn = 1'b0; standby = 1'b0; count_tick = 3'h0; capture_in = 3'h0;
        s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0; s_axi_wvalid = 1'b0;
        s_axi_wstrb = 4'hf; s_axi_bready = 1'b1; s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b1; n_mismatch = 0; total_checks = 0; lfsr_q = 16'h0007;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset values, writes of one to flags
        axi_rd(8'h00, 32'h88, 0);
        axi_rd(8'h04, 32'h88, 0);
        axi_wr(8'h00, 32'hff, 0);
        axi_rd(8'h00, 32'hf8, 0);
        axi_wr(8'h00, 32'h10, 0);
        // Compare match on channel 0 at count 2
        axi_wr(8'h14, 32'h2, 0);
        axi_wr(8'h20, 32'h1, 0);
        tick(3'h1, 3);
        axi_wr(8'h00, 32'h10, 0);
        axi_rd(8'h00, 32'h99, 0);
        chk_pin(match_b_irq, 3'h1);
        axi_wr(8'h00, 32'h10, 0);
        axi_rd(8'h00, 32'h98, 0);
        chk_pin(match_b_irq, 3'h0);
        // Sticky event, mask and clear of the summary line
        axi_rd(8'h24, 32'h1, 0);
        chk_pin({2'b0, irq}, 3'h0);
        axi_wr(8'h28, 32'h1, 0);
        chk_pin({2'b0, irq}, 3'h1);
        axi_wr(8'h24, 32'h1, 0);
        chk_pin({2'b0, irq}, 3'h0);
        // Upward wrap on channel 0
        axi_wr(8'h04, 32'h10, 0);
        axi_wr(8'h08, 32'hffff, 0);
        tick(3'h1, 1);
        axi_rd(8'h08, 32'h0, 0);
        axi_rd(8'h04, 32'h99, 0);
        chk_pin(wrap_irq, 3'h1);
        axi_wr(8'h04, 32'h10, 0);
        // Channel 2 counting down in phase mode
        axi_wr(8'h20, 32'h29, 0);
        axi_wr(8'h10, 32'h1, 0);
        tick(3'h6, 2);
        axi_rd(8'h10, 32'hffff, 0);
        axi_rd(8'h0c, 32'h2, 0);
        axi_rd(8'h04, 32'h9c, 0);
        axi_wr(8'h04, 32'h10, 0);
        // Direction bit: underflow no longer flags
        axi_wr(8'h20, 32'h39, 0);
        axi_wr(8'h10, 32'h1, 0);
        tick(3'h4, 2);
        axi_rd(8'h04, 32'h98, 0);
        // Down bit ignored outside phase mode
        axi_wr(8'h20, 32'h21, 0);
        tick(3'h4, 1);
        axi_rd(8'h10, 32'h0, 0);
        axi_rd(8'h04, 32'h9c, 0);
        // Capture on channel 1 of a random count
        lfsr_q = lfsr_next(lfsr_q);
        axi_wr(8'h20, 32'h201, 0);
        axi_wr(8'h0c, {16'h0, lfsr_q}, 0);
        capture_in <= 3'h2;
        @(posedge aclk);
        capture_in <= 3'h0;
        @(posedge aclk);
        axi_rd(8'h18, {16'h0, lfsr_q}, 0);
        axi_rd(8'h00, 32'h9e, 0);
        // Counter write with a single byte strobe is ignored
        s_axi_wstrb <= 4'h1;
        axi_wr(8'h0c, 32'h5, 0);
        s_axi_wstrb <= 4'hf;
        axi_rd(8'h0c, {16'h0, lfsr_q}, 0);
        // Standby returns all timer registers except the summary event and mask to reset
        standby <= 1'b1;
        repeat (2) @(posedge aclk);
        standby <= 1'b0;
        @(posedge aclk);
        axi_rd(8'h00, 32'h88, 0);
        axi_rd(8'h04, 32'h88, 0);
        axi_rd(8'h0c, 32'h0, 0);
        // Unmapped place refused
        axi_rd(8'h2c, 32'h0, 1);
        axi_wr(8'h2c, 32'h1, 1);
        tally_and_finish();
    end
endmodule : tcbo_timer_bench
